// ---- rtl/sph_regs.svh ----
`ifndef SPH_REGS_SVH
`define SPH_REGS_SVH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SPH_OFF_CTRL 12'h000
`define SPH_OFF_STAT 12'h004
`define SPH_OFF_TXD 12'h008
`define SPH_OFF_RXD 12'h00c

// ----------------------------------------
// control fields
// ----------------------------------------
`define SPH_CTRL_MODE 0
`define SPH_CTRL_BAUD_LSB 1
`define SPH_CTRL_LEN7 4
`define SPH_CTRL_PAR_LSB 5
`define SPH_CTRL_STOP2 7
`define SPH_CTRL_UPD_LSB 8
`define SPH_CTRL_RST 8'h8a

// ----------------------------------------
// status fields
// ----------------------------------------
`define SPH_STAT_RDY 0
`define SPH_STAT_TXFULL 1
`define SPH_STAT_PERR 2
`define SPH_STAT_OVR 3
`define SPH_STAT_FERR 4
`define SPH_STAT_HALT 5
`define SPH_STAT_XOFF 6
`define SPH_STAT_DSR 7
`define SPH_STAT_CNT_LSB 8

// ----------------------------------------
// rates, flow characters, thresholds
// ----------------------------------------
`define SPH_BAUD_300 300
`define SPH_BAUD_600 600
`define SPH_BAUD_1200 1200
`define SPH_BAUD_2400 2400
`define SPH_BAUD_4800 4800
`define SPH_BAUD_9600 9600
`define SPH_BAUD_19200 19200
`define SPH_CLK_HZ 20000000
`define SPH_BUF_DEPTH 96
`define SPH_XOFF_PCT 50
`define SPH_XON_PCT 35
`define SPH_CHAR_XON 8'h11
`define SPH_CHAR_XOFF 8'h13

`endif

// ---- rtl/sph_pkg.sv ----
`default_nettype none
package sph_pkg;
  typedef enum logic {SPH_MODE_CHAR, SPH_MODE_FLOW} sph_mode_type;
  typedef enum logic [1:0] {SPH_PAR_NONE, SPH_PAR_EVEN, SPH_PAR_ODD, SPH_PAR_RSV} sph_par_type;
  typedef enum logic [2:0] {SPH_B300, SPH_B600, SPH_B1200, SPH_B2400, SPH_B4800,
                            SPH_B9600, SPH_B19200, SPH_BRSV} sph_baud_type;
  typedef enum {SPH_RX_IDLE, SPH_RX_START, SPH_RX_BITS} sph_rx_state_type;
endpackage
`default_nettype wire

// ---- rtl/sph_tx.sv ----
`timescale 1ns/1ns
`default_nettype none
module sph_tx (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // frame settings, sampled at frame start
  input wire logic [19:0] bit_div,
  input wire logic len7,
  input wire logic [1:0] par_sel,
  input wire logic stop2,
  // character request
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy,
  // serial line
  output logic txd
);
  logic [11:0] frame;
  logic [3:0] frame_len;
  logic par_on;
  logic par_bit;
  logic [11:0] shift_reg;
  logic [3:0] left_reg;
  logic [19:0] div_reg;
  logic [19:0] cnt_reg;

  assign par_on = (par_sel == sph_pkg::SPH_PAR_EVEN) || (par_sel == sph_pkg::SPH_PAR_ODD);
  assign par_bit = (^data[6:0]) ^ (par_sel == sph_pkg::SPH_PAR_ODD);
  assign frame_len = 4'(1 + (len7 ? 7 : 8) + (par_on ? 1 : 0) + (stop2 ? 2 : 1));

  // idle ones fill the stop bits; msb stays 0 in 8-bit frames
  always_comb begin
    frame = 12'hfff;
    frame[0] = 1'b0;
    frame[7:1] = data[6:0];
    if (!len7) begin
      frame[8] = 1'b0;
    end
    if (par_on) begin
      frame[len7 ? 8 : 9] = par_bit;
    end
  end

  assign busy = (left_reg != 4'h0);

  // settings are copied at the start edge so a change never splits a frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= 12'hfff;
      left_reg <= 4'h0;
      div_reg <= 20'h00001;
      cnt_reg <= 20'h00000;
      txd <= 1'b1;
    end else if (!busy) begin
      txd <= 1'b1;
      if (start) begin
        shift_reg <= frame;
        left_reg <= frame_len;
        div_reg <= bit_div;
        cnt_reg <= 20'h00000;
        txd <= frame[0];
      end
    end else if (cnt_reg == div_reg - 20'h00001) begin
      cnt_reg <= 20'h00000;
      left_reg <= left_reg - 4'h1;
      shift_reg <= {1'b1, shift_reg[11:1]};
      txd <= (left_reg == 4'h1) ? 1'b1 : shift_reg[1];
    end else begin
      cnt_reg <= cnt_reg + 20'h00001;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/sph_serial_port.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "sph_regs.svh"

// Overview of operation
// - hardware mode: transmit only while rts and dtr
// - hardware mode: cts is inverse of receive ready
// - ready set on holding load, cleared by the read that empties the buffer
// - send on rxd line, receive on txd
// - flow mode: terminal ready, xoff halts transmit
// - transmit stops within four or five characters
// - flow mode: xon resumes transmission
// - flow mode: always accept while space remains
// - 96-byte buffer, xoff at half full
// - xon when drained to 35 percent
// - one handshake method at a time
// - mode, baud, length, parity, stop selectable
// - reset: hardware, 9600, 8 bits, none, 2 stop
// - 8-bit: msb sent 0, received msb ignored
// - parity even, odd or none, checked
// - one or two stop bits
// - unselected setting fields stay unchanged
module sph_serial_port #(
  parameter int CLK_HZ = `SPH_CLK_HZ,
  parameter int DEPTH = `SPH_BUF_DEPTH
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial connector, modem side
  output logic rxd_out,
  input wire logic txd_in,
  // handshake lines
  input wire logic rts_in,
  input wire logic dtr_in,
  input wire logic dsr_in,
  output logic cts_out
);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int PW = $clog2(DEPTH);
  localparam logic [CW-1:0] XOFF_LEVEL = CW'(DEPTH * `SPH_XOFF_PCT / 100);
  localparam logic [CW-1:0] XON_LEVEL = CW'(DEPTH * `SPH_XON_PCT / 100);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [19:0] baud_div(input logic [2:0] sel);
    int rate;
    rate = `SPH_BAUD_9600;
    unique case (sel)
      sph_pkg::SPH_B300: rate = `SPH_BAUD_300;
      sph_pkg::SPH_B600: rate = `SPH_BAUD_600;
      sph_pkg::SPH_B1200: rate = `SPH_BAUD_1200;
      sph_pkg::SPH_B2400: rate = `SPH_BAUD_2400;
      sph_pkg::SPH_B4800: rate = `SPH_BAUD_4800;
      sph_pkg::SPH_B19200: rate = `SPH_BAUD_19200;
      default: rate = `SPH_BAUD_9600;
    endcase
    return 20'(CLK_HZ / rate);
  endfunction

  function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  logic line_rx;
  logic rts_s;
  logic dtr_s;
  logic dsr_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 4'hf;
      sync_reg <= 4'hf;
    end else begin
      meta_reg <= {dsr_in, dtr_in, rts_in, txd_in};
      sync_reg <= meta_reg;
    end
  end
  assign line_rx = sync_reg[0];
  assign rts_s = sync_reg[1];
  assign dtr_s = sync_reg[2];
  assign dsr_s = sync_reg[3];

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic acc;
  logic setup;
  logic hit_ctrl;
  logic hit_stat;
  logic hit_txd;
  logic hit_rxd;
  logic mapped;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_txd;
  logic rd_rxd;

  assign acc = psel && penable;
  assign setup = psel && !penable;
  assign hit_ctrl = (paddr == `SPH_OFF_CTRL);
  assign hit_stat = (paddr == `SPH_OFF_STAT);
  assign hit_txd = (paddr == `SPH_OFF_TXD);
  assign hit_rxd = (paddr == `SPH_OFF_RXD);
  assign mapped = hit_ctrl || hit_stat || hit_txd || hit_rxd;
  assign wr_ctrl = acc && pwrite && hit_ctrl;
  assign wr_stat = acc && pwrite && hit_stat;
  assign wr_txd = acc && pwrite && hit_txd;
  assign rd_rxd = acc && !pwrite && hit_rxd;
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ----------------------------------------
  // channel settings
  // ----------------------------------------
  logic [7:0] ctrl_reg;
  logic [7:0] ctrl_next;
  logic [4:0] upd;
  logic flow;
  logic len7;
  logic [1:0] par_sel;
  logic stop2;
  logic [19:0] bit_div;

  // only the fields whose update bit is set are rewritten
  assign upd = pwdata[`SPH_CTRL_UPD_LSB +: 5];
  always_comb begin
    ctrl_next = ctrl_reg;
    if (upd[0]) ctrl_next[`SPH_CTRL_MODE] = pwdata[`SPH_CTRL_MODE];
    if (upd[1]) ctrl_next[`SPH_CTRL_BAUD_LSB +: 3] = pwdata[`SPH_CTRL_BAUD_LSB +: 3];
    if (upd[2]) ctrl_next[`SPH_CTRL_LEN7] = pwdata[`SPH_CTRL_LEN7];
    if (upd[3]) ctrl_next[`SPH_CTRL_PAR_LSB +: 2] = pwdata[`SPH_CTRL_PAR_LSB +: 2];
    if (upd[4]) ctrl_next[`SPH_CTRL_STOP2] = pwdata[`SPH_CTRL_STOP2];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SPH_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_reg <= ctrl_next;
    end
  end

  assign flow = ctrl_reg[`SPH_CTRL_MODE];
  assign len7 = ctrl_reg[`SPH_CTRL_LEN7];
  assign par_sel = ctrl_reg[`SPH_CTRL_PAR_LSB +: 2];
  assign stop2 = ctrl_reg[`SPH_CTRL_STOP2];
  assign bit_div = baud_div(ctrl_reg[`SPH_CTRL_BAUD_LSB +: 3]);

  // ----------------------------------------
  // receiver
  // ----------------------------------------
  sph_pkg::sph_rx_state_type rx_state;
  logic [19:0] rx_cnt_reg;
  logic [19:0] rx_div_reg;
  logic [3:0] rx_idx_reg;
  logic [3:0] rx_last_reg;
  logic [11:0] rx_sh_reg;
  logic rx_len7_reg;
  logic [1:0] rx_par_reg;
  logic rx_done;
  logic [7:0] rx_byte;
  logic rx_pcalc;
  logic rx_perr;
  logic rx_ferr;
  logic rx_par_on;

  assign rx_par_on = (par_sel == sph_pkg::SPH_PAR_EVEN) || (par_sel == sph_pkg::SPH_PAR_ODD);

  // settings are latched at the start bit for the whole frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state <= sph_pkg::SPH_RX_IDLE;
      rx_cnt_reg <= 20'h00000;
      rx_div_reg <= 20'h00001;
      rx_idx_reg <= 4'h0;
      rx_last_reg <= 4'h0;
      rx_sh_reg <= 12'h000;
      rx_len7_reg <= 1'b0;
      rx_par_reg <= 2'h0;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      unique case (rx_state)
        sph_pkg::SPH_RX_IDLE: begin
          if (!line_rx) begin
            rx_state <= sph_pkg::SPH_RX_START;
            rx_cnt_reg <= 20'h00000;
            rx_div_reg <= bit_div;
            rx_len7_reg <= len7;
            rx_par_reg <= par_sel;
            rx_last_reg <= 4'((len7 ? 8 : 9) + (rx_par_on ? 1 : 0));
          end
        end
        sph_pkg::SPH_RX_START: begin
          if (rx_cnt_reg == {1'b0, rx_div_reg[19:1]}) begin
            rx_cnt_reg <= 20'h00000;
            rx_idx_reg <= 4'h1;
            rx_state <= line_rx ? sph_pkg::SPH_RX_IDLE : sph_pkg::SPH_RX_BITS;
          end else begin
            rx_cnt_reg <= rx_cnt_reg + 20'h00001;
          end
        end
        sph_pkg::SPH_RX_BITS: begin
          if (rx_cnt_reg == rx_div_reg - 20'h00001) begin
            rx_cnt_reg <= 20'h00000;
            rx_sh_reg[rx_idx_reg] <= line_rx;
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == rx_last_reg) begin
              rx_state <= sph_pkg::SPH_RX_IDLE;
              rx_done <= 1'b1;
            end
          end else begin
            rx_cnt_reg <= rx_cnt_reg + 20'h00001;
          end
        end
      endcase
    end
  end

  assign rx_byte = {1'b0, rx_sh_reg[7:1]};
  assign rx_pcalc = (^rx_sh_reg[7:1]) ^ (!rx_len7_reg && rx_sh_reg[8]) ^
                    (rx_par_reg == sph_pkg::SPH_PAR_ODD);
  assign rx_perr = ((rx_par_reg == sph_pkg::SPH_PAR_EVEN) || (rx_par_reg == sph_pkg::SPH_PAR_ODD))
                   && (rx_pcalc != rx_sh_reg[rx_len7_reg ? 8 : 9]);
  assign rx_ferr = !rx_sh_reg[rx_last_reg];

  // ----------------------------------------
  // receive holding buffer
  // ----------------------------------------
  logic [7:0] buf_mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic is_flow_char;
  logic push;
  logic pop;
  logic room;
  logic overrun;
  logic rx_ready;

  // no buffer in hardware mode: a single held character
  assign room = flow ? (count_reg != CW'(DEPTH)) : (count_reg == '0);
  assign is_flow_char = flow && ((rx_byte == `SPH_CHAR_XOFF) || (rx_byte == `SPH_CHAR_XON));
  assign push = rx_done && !is_flow_char && room;
  assign overrun = rx_done && !is_flow_char && !room;
  assign pop = rd_rxd && (count_reg != '0);
  assign rx_ready = (count_reg != '0);

  always_ff @(posedge pclk) begin
    if (push) begin
      buf_mem[wr_ptr_reg] <= rx_byte;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      if (push && !pop) count_reg <= count_reg + CW'(1);
      else if (pop && !push) count_reg <= count_reg - CW'(1);
    end
  end

  // ----------------------------------------
  // flow control state
  // ----------------------------------------
  logic halt_reg;
  logic xoff_sent_reg;
  logic want_xoff;
  logic want_xon;

  assign want_xoff = flow && !xoff_sent_reg && (count_reg >= XOFF_LEVEL);
  assign want_xon = flow && xoff_sent_reg && (count_reg <= XON_LEVEL);

  // ----------------------------------------
  // transmit path
  // ----------------------------------------
  logic [7:0] tx_hold_reg;
  logic tx_full_reg;
  logic tx_busy;
  logic term_ready;
  logic send_ctl;
  logic send_data;
  logic tx_start;
  logic [7:0] tx_byte;

  // terminal readiness depends on the single active method
  assign term_ready = flow ? !halt_reg : (rts_s && dtr_s);
  assign send_ctl = !tx_busy && (want_xoff || want_xon);
  assign send_data = !tx_busy && !send_ctl && tx_full_reg && term_ready;
  assign tx_start = send_ctl || send_data;
  assign tx_byte = send_ctl ? (want_xoff ? `SPH_CHAR_XOFF : `SPH_CHAR_XON) : tx_hold_reg;

  // halting only blocks the next data frame start, so the current frame finishes and xon or xoff can still go
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_reg <= 1'b0;
      xoff_sent_reg <= 1'b0;
      tx_hold_reg <= 8'h00;
      tx_full_reg <= 1'b0;
    end else begin
      if (!flow) begin
        halt_reg <= 1'b0;
      end else if (rx_done && rx_byte == `SPH_CHAR_XOFF) begin
        halt_reg <= 1'b1;
      end else if (rx_done && rx_byte == `SPH_CHAR_XON) begin
        halt_reg <= 1'b0;
      end
      if (!flow) begin
        xoff_sent_reg <= 1'b0;
      end else if (send_ctl) begin
        xoff_sent_reg <= want_xoff;
      end
      if (wr_txd && !tx_full_reg) begin
        tx_hold_reg <= pwdata[7:0];
        tx_full_reg <= 1'b1;
      end else if (send_data) begin
        tx_full_reg <= 1'b0;
      end
    end
  end

  sph_tx sph_tx_inst (
    .pclk(pclk),
    .presetn(presetn),
    .bit_div(bit_div),
    .len7(len7),
    .par_sel(par_sel),
    .stop2(stop2),
    .start(tx_start),
    .data(tx_byte),
    .busy(tx_busy),
    .txd(rxd_out)
  );

  // ----------------------------------------
  // handshake output
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cts_out <= 1'b1;
    end else begin
      cts_out <= flow ? 1'b1 : !rx_ready;
    end
  end

  // ----------------------------------------
  // status and read data
  // ----------------------------------------
  logic perr_reg;
  logic ovr_reg;
  logic ferr_reg;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  // a new error in the clearing cycle wins over the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      perr_reg <= 1'b0;
      ovr_reg <= 1'b0;
      ferr_reg <= 1'b0;
    end else begin
      perr_reg <= (rx_done && rx_perr) ||
                  (perr_reg && !(wr_stat && pwdata[`SPH_STAT_PERR]));
      ovr_reg <= overrun || (ovr_reg && !(wr_stat && pwdata[`SPH_STAT_OVR]));
      ferr_reg <= (rx_done && rx_ferr) || (ferr_reg && !(wr_stat && pwdata[`SPH_STAT_FERR]));
    end
  end

  always_comb begin
    stat_word = 32'h00000000;
    stat_word[`SPH_STAT_RDY] = rx_ready;
    stat_word[`SPH_STAT_TXFULL] = tx_full_reg;
    stat_word[`SPH_STAT_PERR] = perr_reg;
    stat_word[`SPH_STAT_OVR] = ovr_reg;
    stat_word[`SPH_STAT_FERR] = ferr_reg;
    stat_word[`SPH_STAT_HALT] = halt_reg;
    stat_word[`SPH_STAT_XOFF] = xoff_sent_reg;
    stat_word[`SPH_STAT_DSR] = dsr_s;
    stat_word[`SPH_STAT_CNT_LSB +: 8] = 8'(count_reg);
  end

  assign rd_word = hit_ctrl ? {24'h000000, ctrl_reg} :
                   hit_stat ? stat_word :
                   hit_txd ? {24'h000000, tx_hold_reg} :
                   (hit_rxd && rx_ready) ? {24'h000000, buf_mem[rd_ptr_reg]} : 32'h00000000;

  // read data is latched in the setup cycle and stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      prdata <= rd_word;
    end
  end
endmodule
`default_nettype wire

// ---- verif/sph_serial_port_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----
// port checker
// ----
module sph_serial_port_checker #(
  parameter int CLK_HZ = 20000000
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // serial
  input wire logic rxd_out,
  input wire logic rts_in,
  input wire logic dtr_in,
  input wire logic cts_out
);
  localparam int MINB = CLK_HZ / 19200;
  localparam int GATE = 9 * (CLK_HZ / 300);
  logic flow_reg;
  logic [15:0] low_cnt;
  logic [15:0] hold_cnt;
  wire acc = psel && penable;
  wire bad_addr = paddr > 12'h00c || paddr[1:0] != 2'h0;
  wire pop = acc && !pwrite && paddr == 12'h00c;
  // idle time only, so a frame already in flight never trips the gate check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_reg <= 1'b0;
      low_cnt <= 16'h0;
      hold_cnt <= 16'h0;
    end else begin
      if (acc && pwrite && paddr == 12'h000 && pwdata[8]) begin
        flow_reg <= pwdata[0];
      end
      low_cnt <= rxd_out ? 16'h0 : low_cnt + 16'h1;
      hold_cnt <= (!flow_reg && !(rts_in && dtr_in) && rxd_out) ? hold_cnt + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reset_idle_a: assert property ($rose(presetn) |-> rxd_out && cts_out)
    else $error("line or cts not idle after reset");
  bad_addr_a: assert property (acc && bad_addr |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access not refused");
  err_quiet_a: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  good_addr_a: assert property (acc && !bad_addr |-> !pslverr)
    else $error("pslverr on mapped address");
  start_width_a: assert property ($rose(rxd_out) |-> low_cnt >= MINB)
    else $error("low bit shorter than fastest rate");
  hw_gate_a: assert property (hold_cnt >= GATE |=> rxd_out)
    else $error("frame sent while terminal not ready");
  flow_cts_a: assert property (flow_reg && $past(flow_reg) |-> cts_out)
    else $error("cts low in flow mode");
  cts_pop_a: assert property (!flow_reg && pop |-> ##[1:3] cts_out)
    else $error("cts not back after read");
  cts_hold_a: assert property (!flow_reg && !cts_out && !pop && !$past(pop)
    && !$past(pop, 2) |=> !cts_out)
    else $error("cts rose without a read");
endmodule
bind sph_serial_port sph_serial_port_checker #(.CLK_HZ(CLK_HZ)) sph_serial_port_checker_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pslverr(pslverr), .rxd_out(rxd_out),
  .rts_in(rts_in), .dtr_in(dtr_in), .cts_out(cts_out));
`default_nettype wire

// ---- verif/sph_term_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----
// modem-side terminal
// ----
module sph_term_model #(
  parameter int BIT = 10
) (
  // clock
  input wire logic pclk,
  // serial lines
  input wire logic rxd_out,
  output logic txd_in,
  // handshake lines
  output logic rts_in,
  output logic dtr_in,
  output logic dsr_in,
  input wire logic cts_out
);
  logic [8:0] got[$];
  bit hw = 1'b1;
  int nbits = 8;
  int par = 0;
  int nstop = 2;
  initial begin
    txd_in = 1'b1;
    rts_in = 1'b1;
    dtr_in = 1'b1;
    dsr_in = 1'b1;
  end
  task automatic cfg(input bit h, input int n, input int p, input int s);
    hw = h;
    nbits = n;
    par = p;
    nstop = s;
    got.delete();
  endtask
  task automatic gate(input logic r, input logic d);
    @(posedge pclk);
    rts_in <= r;
    dtr_in <= d;
  endtask
  // bad flips parity on purpose
  task automatic send(input logic [7:0] b, input logic bad);
    logic p;
    p = ^(b & (nbits == 7 ? 8'h7f : 8'hff)) ^ (par == 2) ^ bad;
    if (hw) wait (cts_out === 1'b1);
    @(posedge pclk);
    txd_in <= 1'b0;
    repeat (BIT) @(posedge pclk);
    for (int i = 0; i < nbits; i++) begin
      txd_in <= b[i];
      repeat (BIT) @(posedge pclk);
    end
    if (par != 0) begin
      txd_in <= p;
      repeat (BIT) @(posedge pclk);
    end
    txd_in <= 1'b1;
    repeat (BIT * nstop) @(posedge pclk);
  endtask
  // samples mid-bit; data lsb first, parity next
  always begin
    logic [8:0] v;
    @(negedge rxd_out);
    v = 9'h0;
    repeat (BIT / 2) @(posedge pclk);
    for (int i = 0; i < nbits + (par != 0); i++) begin
      repeat (BIT) @(posedge pclk);
      v[i] = rxd_out;
    end
    repeat (BIT) @(posedge pclk);
    got.push_back(v);
  end
endmodule
`default_nettype wire

// ---- verif/serial_port_handshake_control_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module serial_port_handshake_control_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic rxd_out, txd_in, rts_in, dtr_in, dsr_in, cts_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int error_cnt = 0;
  int n_compared = 0;
  // 96 kHz nominal gives ten cycles a bit at 9600
  sph_serial_port #(.CLK_HZ(96000), .DEPTH(96)) sph_serial_port_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd_out(rxd_out), .txd_in(txd_in), .rts_in(rts_in), .dtr_in(dtr_in),
    .dsr_in(dsr_in), .cts_out(cts_out));
  sph_term_model #(.BIT(10)) sph_term_model_inst (
    .pclk(pclk), .rxd_out(rxd_out), .txd_in(txd_in), .rts_in(rts_in),
    .dtr_in(dtr_in), .dsr_in(dsr_in), .cts_out(cts_out));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] gq(input int i);
    return {23'h0, sph_term_model_inst.got[i]};
  endfunction
  task automatic wait_got(input int n);
    for (int i = 0; i < 4000 && sph_term_model_inst.got.size() < n; i++) @(posedge pclk);
  endtask
  task automatic t_reset();
    apb(1'b0, 12'h000, 32'h0);
    check("ctrl", rd, 32'h8a);
    apb(1'b0, 12'h004, 32'h0);
    check("status", rd, 32'h80);
    apb(1'b0, 12'h010, 32'h0);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, 12'h010, 32'h0);
    check("unmapped wr", {31'h0, err}, 32'h1);
    check("pready", {31'h0, pready}, 32'h1);
    $display("reset test done");
  endtask
  task automatic t_hw();
    sph_term_model_inst.cfg(1'b1, 8, 0, 2);
    apb(1'b1, 12'h008, 32'hc5);
    wait_got(1);
    check("tx msb", gq(0), 32'h45);
    sph_term_model_inst.gate(1'b0, 1'b1);
    apb(1'b1, 12'h008, 32'h12);
    repeat (3000) @(posedge pclk);
    check("gated", sph_term_model_inst.got.size(), 32'h1);
    sph_term_model_inst.gate(1'b1, 1'b1);
    wait_got(2);
    check("ungated", gq(1), 32'h12);
    sph_term_model_inst.gate(1'b1, 1'b0);
    apb(1'b1, 12'h008, 32'h34);
    repeat (300) @(posedge pclk);
    check("dtr gated", sph_term_model_inst.got.size(), 32'h2);
    sph_term_model_inst.gate(1'b1, 1'b1);
    wait_got(3);
    check("dtr ungated", gq(2), 32'h34);
    sph_term_model_inst.send(8'ha7, 1'b0);
    repeat (20) @(posedge pclk);
    check("cts low", {31'h0, cts_out}, 32'h0);
    // second character ignores cts on purpose: the held one must survive
    sph_term_model_inst.hw = 1'b0;
    sph_term_model_inst.send(8'h55, 1'b0);
    sph_term_model_inst.hw = 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    check("ready", rd & 32'h9, 32'h9);
    apb(1'b0, 12'h00c, 32'h0);
    check("rx msb", rd, 32'h27);
    repeat (4) @(posedge pclk);
    check("cts back", {31'h0, cts_out}, 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check("ready clr", rd & 32'h1, 32'h0);
    $display("handshake test done");
  endtask
  task automatic t_format();
    logic [31:0] c;
    for (int k = 1; k < 3; k++) begin
      c = 32'h1f1a | (k << 5);
      apb(1'b1, 12'h000, c);
      sph_term_model_inst.cfg(1'b1, 7, k, 1);
      apb(1'b1, 12'h008, 32'h35);
      wait_got(1);
      check("parity out", gq(0), 32'h35 | ((k - 1) << 7));
      sph_term_model_inst.send(8'h35, 1'b1);
      apb(1'b0, 12'h004, 32'h0);
      check("parity err", rd & 32'h4, 32'h4);
      apb(1'b0, 12'h00c, 32'h0);
      check("rx 7 bit", rd, 32'h35);
      apb(1'b1, 12'h004, 32'h4);
      apb(1'b0, 12'h000, 32'h0);
      check("ctrl", rd, c & 32'hff);
    end
    apb(1'b1, 12'h000, 32'h020c);
    apb(1'b0, 12'h000, 32'h0);
    check("partial", rd, 32'h5c);
    apb(1'b1, 12'h000, 32'h1f8a);
    $display("format test done");
  endtask
  task automatic t_flow();
    apb(1'b1, 12'h000, 32'h0101);
    sph_term_model_inst.cfg(1'b0, 8, 0, 2);
    for (int i = 0; i < 48; i++) sph_term_model_inst.send(8'h20 + i[7:0], 1'b0);
    wait_got(1);
    check("xoff out", gq(0), 32'h13);
    apb(1'b0, 12'h004, 32'h0);
    check("count", rd & 32'hff40, 32'h3040);
    check("cts flow", {31'h0, cts_out}, 32'h1);
    sph_term_model_inst.send(8'h13, 1'b0);
    apb(1'b1, 12'h008, 32'h5a);
    repeat (300) @(posedge pclk);
    check("halted", sph_term_model_inst.got.size(), 32'h1);
    apb(1'b0, 12'h004, 32'h0);
    check("halt flag", rd & 32'hff22, 32'h3022);
    sph_term_model_inst.send(8'h11, 1'b0);
    wait_got(2);
    check("resume", gq(1), 32'h5a);
    for (int i = 0; i < 15; i++) begin
      apb(1'b0, 12'h00c, 32'h0);
      check("drain", rd, 32'h20 + i);
    end
    wait_got(3);
    check("xon out", gq(2), 32'h11);
    apb(1'b0, 12'h004, 32'h0);
    check("flags", rd & 32'hff40, 32'h2100);
    $display("flow test done");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_hw();
    t_format();
    t_flow();
    summarize();
  end
  // about six times the longest expected run
  initial begin
    repeat (60000) @(posedge pclk);
    error_cnt++;
    $display("watchdog expired");
    summarize();
  end
endmodule
`default_nettype wire
